// ==== hdl/ldsc_pkg.sv ====
// Constants for the second state-control command decoder of the serial LED driver.
package ldsc_pkg;
  // Width of the shift register and of the state control word.
  localparam int unsigned LDSC_WORD_W = 16;
  localparam int unsigned LDSC_CHANNELS = 16;
  // Shift clock pulse counts, taken while the strobe is high, that mean this command.
  localparam logic [3:0] LDSC_CMD_PULSES_A = 4'h9;
  localparam logic [3:0] LDSC_CMD_PULSES_B = 4'ha;
  localparam logic [3:0] LDSC_CNT_MAX = 4'hf;
  localparam logic [3:0] LDSC_CNT_FIRST = 4'h1;
  // Bit positions in the state control word.
  localparam int unsigned LDSC_THERMAL_DISABLE_BIT = 15;
  localparam int unsigned LDSC_OPEN_DETECT_ENABLE_BIT = 14;
  localparam int unsigned LDSC_SHORT_DETECT_ENABLE_BIT = 13;
  localparam int unsigned LDSC_PRE_STANDBY_BIT = 12;
  localparam int unsigned LDSC_SHORT_THRESHOLD_SELECT_BIT = 11;
  localparam int unsigned LDSC_STAGGER_ENABLE_BIT = 10;
  localparam int unsigned LDSC_OUT_EDGE_SELECT_BIT = 9;
  localparam int unsigned LDSC_TEST_HI_BIT = 8;
  localparam int unsigned LDSC_TEST_LO_BIT = 3;
  // Every bit of the state control word clears to zero at power-up.
  localparam logic [15:0] LDSC_STATE_RESET = 16'h0000;
  // Switching order of the outputs with staggering on; entry k sits at bits 4k+3..4k.
  localparam logic [63:0] LDSC_STAGGER_ORDER = {
    4'hb, 4'h4, 4'hc, 4'h3, 4'ha, 4'h5, 4'hd, 4'h2,
    4'h9, 4'h6, 4'he, 4'h1, 4'h8, 4'h7, 4'hf, 4'h0};
  // Delay between neighbouring outputs in the stagger sequence.
  localparam int unsigned LDSC_SYS_PERIOD_NS = 8;
  localparam int unsigned LDSC_STAGGER_DELAY_NS = 40;
  localparam int unsigned LDSC_STAGGER_CYCLES_INT =
    (LDSC_STAGGER_DELAY_NS + LDSC_SYS_PERIOD_NS - 1) / LDSC_SYS_PERIOD_NS;
  localparam logic [3:0] LDSC_STAGGER_CYCLES = LDSC_STAGGER_CYCLES_INT[3:0];
endpackage

// ==== hdl/ldsc_state_control_two.sv ====
// Serial decoder and state control register for the second state-setting command.
`timescale 1ns/1ps
module ldsc_state_control_two (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic shift_clk,
  input wire logic serial_data_in,
  input wire logic transfer_strobe,
  output logic serial_data_out,
  input wire logic [ldsc_pkg::LDSC_CHANNELS-1:0] latch_data,
  input wire logic [ldsc_pkg::LDSC_CHANNELS-1:0] output_request,
  input wire logic temp_above_trip,
  input wire logic temp_below_release,
  output logic [ldsc_pkg::LDSC_CHANNELS-1:0] output_drive,
  output logic outputs_forced_off,
  output logic state_set_two_command,
  output logic thermal_shutdown_enable,
  output logic open_detect_enable,
  output logic short_detect_enable,
  output logic short_threshold_select,
  output logic stagger_enable,
  output logic [5:0] test_mode,
  output logic standby
);
  import ldsc_pkg::*;

  // State of the logic that runs on the host's shift clock.
  typedef struct packed {
    logic [15:0] shreg;
    logic [15:0] snap;
    logic [3:0] snap_cnt;
    logic [3:0] cnt;
    logic strb_prev;
    logic edge_s1;
    logic edge_s2;
  } ldsc_link_t;

  // State of the logic on the system clock.
  typedef struct packed {
    logic strb_s1;
    logic strb_s2;
    logic strb_d;
    logic hi_s1;
    logic hi_s2;
    logic lo_s1;
    logic lo_s2;
    logic [15:0] ctrl;
    logic cmd;
    logic hot;
    logic off;
    logic stby;
    logic [3:0] ptr;
    logic [3:0] tick;
    logic [15:0] drive;
  } ldsc_sys_t;

  logic [1:0] rst_sync;
  logic rst_n;
  ldsc_link_t link;
  ldsc_link_t next_link;
  ldsc_sys_t sys;
  ldsc_sys_t next_sys;
  logic serial_data_out_fall;
  logic strobe_fell;
  logic cmd_match;
  logic step;
  logic [3:0] cur_chan;
  logic [15:0] upd;

  // Reset release through two flops; assertion stays asynchronous.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Link side: shift, count shift clock pulses while the strobe is high and keep a snapshot of the word.
  // The shift clock may stop once the strobe drops, so the snapshot is taken on
  // every strobe-high edge and is left still for the system side to read.
  always_comb begin
    next_link = link;
    next_link.shreg = {link.shreg[14:0], serial_data_in};
    next_link.strb_prev = transfer_strobe;
    next_link.edge_s1 = sys.ctrl[LDSC_OUT_EDGE_SELECT_BIT];
    next_link.edge_s2 = link.edge_s1;
    if (transfer_strobe) begin
      if (!link.strb_prev) begin
        next_link.cnt = LDSC_CNT_FIRST;
      end else if (link.cnt != LDSC_CNT_MAX) begin
        next_link.cnt = link.cnt + 4'h1;
      end
      next_link.snap = {link.shreg[14:0], serial_data_in};
      next_link.snap_cnt = next_link.cnt;
    end
  end

  always_ff @(posedge shift_clk or negedge resetn) begin
    if (!resetn) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  // Copy of the last stage for a serial output that moves on the falling edge.
  always_ff @(negedge shift_clk or negedge resetn) begin
    if (!resetn) begin
      serial_data_out_fall <= 1'b0;
    end else begin
      serial_data_out_fall <= link.shreg[15];
    end
  end

  // The edge choice crosses into the link domain through two flops.
  assign serial_data_out = link.edge_s2 ? serial_data_out_fall : link.shreg[15];

  // The strobe is seen only after synchronising; by then the snapshot is stable.
  assign strobe_fell = sys.strb_d && !sys.strb_s2;
  assign cmd_match = (link.snap_cnt == LDSC_CMD_PULSES_A) ||
    (link.snap_cnt == LDSC_CMD_PULSES_B);

  // Stagger steps advance one channel per delay period, in the fixed order.
  assign step = (sys.tick == LDSC_STAGGER_CYCLES - 4'h1);
  assign cur_chan = LDSC_STAGGER_ORDER[{sys.ptr, 2'h0} +: 4];

  // Each channel follows its request at once, or only on its own stagger slot.
  for (genvar c = 0; c < LDSC_CHANNELS; c++) begin : g_chan
    assign upd[c] = !sys.ctrl[LDSC_STAGGER_ENABLE_BIT] ||
      (step && (cur_chan == 4'(c)));
  end

  // System side next state.
  always_comb begin
    next_sys = sys;
    next_sys.strb_s1 = transfer_strobe;
    next_sys.strb_s2 = sys.strb_s1;
    next_sys.strb_d = sys.strb_s2;
    next_sys.hi_s1 = temp_above_trip;
    next_sys.hi_s2 = sys.hi_s1;
    next_sys.lo_s1 = temp_below_release;
    next_sys.lo_s2 = sys.lo_s1;
    next_sys.cmd = strobe_fell && cmd_match;
    // Any other pulse count leaves the state word untouched.
    if (strobe_fell && cmd_match) begin
      next_sys.ctrl = link.snap;
    end
    // Trip sets the hot flag and release clears it; trip wins if both show.
    if (sys.hi_s2) begin
      next_sys.hot = 1'b1;
    end else if (sys.lo_s2) begin
      next_sys.hot = 1'b0;
    end
    next_sys.off = sys.hot && !sys.ctrl[LDSC_THERMAL_DISABLE_BIT];
    next_sys.stby = sys.ctrl[LDSC_PRE_STANDBY_BIT] && (latch_data == 16'h0000);
    // The stagger timer runs freely so a change waits at most one full round.
    next_sys.tick = step ? 4'h0 : sys.tick + 4'h1;
    if (step) begin
      next_sys.ptr = sys.ptr + 4'h1;
    end
    for (int i = 0; i < LDSC_CHANNELS; i++) begin
      if (sys.off) begin
        next_sys.drive[i] = 1'b0;
      end else if (upd[i]) begin
        next_sys.drive[i] = output_request[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys <= '0;
    end else begin
      sys <= next_sys;
    end
  end

  // Register bits drive the analog controls directly.
  assign thermal_shutdown_enable = !sys.ctrl[LDSC_THERMAL_DISABLE_BIT];
  assign open_detect_enable = sys.ctrl[LDSC_OPEN_DETECT_ENABLE_BIT];
  assign short_detect_enable = sys.ctrl[LDSC_SHORT_DETECT_ENABLE_BIT];
  assign short_threshold_select = sys.ctrl[LDSC_SHORT_THRESHOLD_SELECT_BIT];
  assign stagger_enable = sys.ctrl[LDSC_STAGGER_ENABLE_BIT];
  assign test_mode = sys.ctrl[LDSC_TEST_HI_BIT:LDSC_TEST_LO_BIT];
  // Standby only powers down analog parts; the serial path keeps running.
  assign standby = sys.stby;
  assign outputs_forced_off = sys.off;
  assign output_drive = sys.drive;
  assign state_set_two_command = sys.cmd;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // A matching strobe fall loads the snapshot on the next edge.
  a_cmd_load: assert property ((strobe_fell && cmd_match) |=>
    (sys.ctrl == $past(link.snap)) && state_set_two_command)
    else $error("state word not loaded on command");

  // Any other pulse count leaves the word alone.
  a_cmd_ignore: assert property ((strobe_fell && !cmd_match) |=>
    $stable(sys.ctrl) && !state_set_two_command)
    else $error("state word changed on wrong pulse count");

  // Protection disabled means outputs are never forced off.
  a_tsd_disabled: assert property (sys.ctrl[LDSC_THERMAL_DISABLE_BIT] |=>
    !outputs_forced_off)
    else $error("outputs forced off while protection disabled");

  // Hot die with protection on forces outputs off, then drive goes to zero.
  a_tsd_trip: assert property ((sys.hot && thermal_shutdown_enable) ##1
    thermal_shutdown_enable |=> output_drive == 16'h0000)
    else $error("outputs still driven after thermal trip");

  // Pre-standby with an empty latch enters standby.
  a_standby_entry: assert property ((sys.ctrl[LDSC_PRE_STANDBY_BIT] &&
    latch_data == 16'h0000) |=> standby)
    else $error("standby not entered with empty latch");

  // Any set latch bit keeps the device in normal operation.
  a_standby_exit: assert property ((latch_data != 16'h0000) |=> !standby)
    else $error("standby with latch bits set");

  // Without staggering every output follows its request one edge later.
  a_stagger_off: assert property ((!stagger_enable && !sys.off) |=>
    output_drive == $past(output_request))
    else $error("output did not follow request");

  // With staggering at most one output changes per edge.
  a_stagger_one: assert property ((stagger_enable && !sys.off) |=>
    $countones(output_drive ^ $past(output_drive)) <= 1)
    else $error("several outputs switched together");

  // After reset release the state word holds its defaults.
  a_reset_default: assert property ($rose(rst_n) |->
    sys.ctrl == LDSC_STATE_RESET && !standby)
    else $error("state word not at default after reset");

  // Every strobe-high shift edge captures the word just shifted.
  a_link_snap: assert property (@(posedge shift_clk) disable iff (!resetn)
    transfer_strobe |=> link.snap == link.shreg)
    else $error("snapshot does not match shift register");

  // The load pulse lasts one system cycle only.
  a_cmd_pulse_one: assert property (state_set_two_command |=>
    !state_set_two_command)
    else $error("command pulse longer than one cycle");

  // The state word moves only on a recognised command.
  a_state_hold: assert property (!(strobe_fell && cmd_match) |=>
    $stable(sys.ctrl))
    else $error("state word changed without a command");

  // A synchronised trip sets the hot flag even if release shows too.
  a_hot_set_wins: assert property (sys.hi_s2 |=> sys.hot)
    else $error("hot flag not set on trip");

  // Release without trip clears the hot flag.
  a_hot_release: assert property ((sys.lo_s2 && !sys.hi_s2) |=> !sys.hot)
    else $error("hot flag not cleared on release");

  // Forcing off clears every output on the next edge, staggering or not.
  a_forced_drive: assert property (outputs_forced_off |=>
    output_drive == 16'h0000)
    else $error("outputs driven while forced off");

  // Between stagger slots no output moves.
  a_stagger_hold: assert property ((stagger_enable && !sys.off && !step) |=>
    $stable(output_drive))
    else $error("output switched outside its stagger slot");

  // Without the pre-standby bit the device never enters standby.
  a_standby_pre_off: assert property (!sys.ctrl[LDSC_PRE_STANDBY_BIT] |=> !standby)
    else $error("standby without pre-standby bit");

  // The first strobe-high edge after a strobe-low edge restarts the pulse count.
  a_cnt_restart: assert property (@(posedge shift_clk) disable iff (!resetn)
    (transfer_strobe && !link.strb_prev) |=> link.cnt == LDSC_CNT_FIRST)
    else $error("pulse count did not restart");

  // A long strobe parks the count at its top so it cannot wrap back to a legal value.
  a_cnt_saturate: assert property (@(posedge shift_clk) disable iff (!resetn)
    (transfer_strobe && link.strb_prev && link.cnt == LDSC_CNT_MAX) |=>
    link.cnt == LDSC_CNT_MAX)
    else $error("pulse count wrapped");

endmodule

// ==== bench/ldsc_host_model.sv ====
// Host model that shifts state words into the driver over the serial link.
`timescale 1ns/1ps
module ldsc_host_model (
  output logic shift_clk,
  output logic serial_data_in,
  output logic transfer_strobe
);
  // The link rests with its clock low and the strobe low between frames.
  initial begin
    shift_clk = 1'b0;
    serial_data_in = 1'b0;
    transfer_strobe = 1'b0;
  end
  // Shifts one word, most significant bit first, strobe up over the last n rising edges.
  task automatic send(input logic [15:0] w, input int n);
    // A short offset keeps the link edges apart from the system clock edges.
    #7;
    for (int i = 15; i >= 0; i--) begin
      serial_data_in = w[i];
      transfer_strobe = (i < n);
      #40 shift_clk = 1'b1;
      #40 shift_clk = 1'b0;
    end
    // Data is not held after the frame, so the line shows the inverse of the last bit.
    transfer_strobe = 1'b0;
    serial_data_in = ~w[0];
  endtask
endmodule

// ==== bench/tb_led_driver_state_control_two.sv ====
// Self-checking testbench for the second state-control command decoder.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module tb_led_driver_state_control_two;
  import ldsc_pkg::*;
  logic clk_sys, resetn, shift_clk, serial_data_in, transfer_strobe, serial_data_out;
  logic [15:0] latch_data, output_request, output_drive, prev;
  logic temp_above_trip, temp_below_release, outputs_forced_off, state_set_two_command;
  logic thermal_shutdown_enable, open_detect_enable, short_detect_enable;
  logic short_threshold_select, stagger_enable, standby;
  logic [5:0] test_mode;
  int n_errors = 0;
  int samples_checked = 0;
  int ord[16] = '{0, 15, 7, 8, 1, 14, 6, 9, 2, 13, 5, 10, 3, 12, 4, 11};
  int p, pf, gap;

  ldsc_host_model u_ldsc_host_model (.shift_clk(shift_clk), .serial_data_in(serial_data_in),
    .transfer_strobe(transfer_strobe));
  ldsc_state_control_two u_ldsc_state_control_two (.clk_sys(clk_sys), .resetn(resetn),
    .shift_clk(shift_clk), .serial_data_in(serial_data_in), .transfer_strobe(transfer_strobe),
    .serial_data_out(serial_data_out), .latch_data(latch_data), .output_request(output_request),
    .temp_above_trip(temp_above_trip), .temp_below_release(temp_below_release),
    .output_drive(output_drive), .outputs_forced_off(outputs_forced_off),
    .state_set_two_command(state_set_two_command),
    .thermal_shutdown_enable(thermal_shutdown_enable), .open_detect_enable(open_detect_enable),
    .short_detect_enable(short_detect_enable), .short_threshold_select(short_threshold_select),
    .stagger_enable(stagger_enable), .test_mode(test_mode), .standby(standby));

  // System clock at 125 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Sends a word, then watches a bounded span for the load pulse.
  task automatic frame(input logic [15:0] w, input int n, input logic exp);
    logic seen;
    u_ldsc_host_model.send(w, n);
    seen = 1'b0;
    repeat (40) @(negedge clk_sys) if (state_set_two_command === 1'b1) seen = 1'b1;
    `CHK(seen, exp)
    `CHK(serial_data_out, w[15])
  endtask

  // Cuts a hang short; the tests take well under this span.
  initial begin
    #200us;
    n_errors++;
    finish_test();
  end

  // Main sequence of tests.
  initial begin
    resetn = 1'b0;
    latch_data = 16'h0000;
    output_request = 16'h0000;
    temp_above_trip = 1'b0;
    temp_below_release = 1'b0;
    repeat (6) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    `CHK({thermal_shutdown_enable, open_detect_enable, short_detect_enable}, 3'h4)
    `CHK({short_threshold_select, stagger_enable, test_mode, standby}, 9'h000)
    frame(16'h7e00, 9, 1'b1);
    `CHK({thermal_shutdown_enable, open_detect_enable, short_detect_enable}, 3'h7)
    `CHK({short_threshold_select, stagger_enable, test_mode}, 8'hc0)
    `CHK(standby, 1'b1)
    latch_data = 16'h0001;
    repeat (3) @(negedge clk_sys);
    `CHK(standby, 1'b0)
    // Loads must still land while the device sits in standby.
    latch_data = 16'h0000;
    repeat (3) @(negedge clk_sys);
    `CHK(standby, 1'b1)
    // Pulse counts either side of the legal pair must leave the word alone.
    frame(16'h8000, 8, 1'b0);
    // Falling-edge output: just after the first rising edge the old last stage still shows.
    fork
      frame(16'h8000, 11, 1'b0);
      begin
        @(posedge shift_clk);
        #20;
        `CHK(serial_data_out, 1'b1)
      end
    join
    `CHK(thermal_shutdown_enable, 1'b1)
    frame(16'h8000, 10, 1'b1);
    `CHK({thermal_shutdown_enable, open_detect_enable, stagger_enable}, 3'h0)
    // Protection off: the trip input must be ignored.
    output_request = 16'hffff;
    temp_above_trip = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK({outputs_forced_off, output_drive}, 17'h0ffff)
    // Clear the latched hot flag before protection comes back on.
    temp_above_trip = 1'b0;
    temp_below_release = 1'b1;
    frame(16'h0000, 9, 1'b1);
    temp_below_release = 1'b0;
    `CHK({outputs_forced_off, output_drive}, 17'h0ffff)
    temp_above_trip = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK({outputs_forced_off, output_drive}, 17'h10000)
    temp_above_trip = 1'b0;
    temp_below_release = 1'b1;
    repeat (8) @(negedge clk_sys);
    `CHK({outputs_forced_off, output_drive}, 17'h0ffff)
    temp_below_release = 1'b0;
    output_request = 16'h0000;
    frame(16'h0400, 10, 1'b1);
    repeat (100) @(negedge clk_sys);
    `CHK(output_drive, 16'h0000)
    // Outputs must come on one at a time, in the fixed order, five cycles apart.
    output_request = 16'hffff;
    prev = 16'h0000;
    p = -1;
    for (int k = 0; k < 16; k++) begin
      gap = 0;
      while (output_drive === prev && gap < 200) begin
        @(negedge clk_sys);
        gap++;
      end
      pf = -1;
      for (int j = 0; j < 16; j++) if (output_drive === (prev | (16'h1 << ord[j]))) pf = j;
      if (k > 0) `CHK(pf, (p + 1) % 16)
      if (k > 0) `CHK(gap, 5)
      p = pf;
      prev = output_drive;
    end
    `CHK(output_drive, 16'hffff)
    finish_test();
  end
endmodule
